/* File: ccseq_pkg.sv */
/*
  Shared constants and types for the charge control sequencer.
  Assumes a 20 MHz system clock; all timing counts derive from it.
*/
package ccseq_pkg;

  // System clock rate
  localparam int unsigned CLK_HZ = 20000000;

  // Time base: one tick per millisecond
  localparam int unsigned TICK_US     = 1000;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000000 * TICK_US;

  // Deglitch and pulse times in microseconds
  localparam int unsigned OCP_DGL_US  = 30;
  localparam int unsigned TSD_DGL_US  = 10;
  localparam int unsigned SLP_DGL_US  = 120;
  localparam int unsigned IRQ_PULSE_US = 128;
  localparam int unsigned OCP_DGL_CYC = OCP_DGL_US * (CLK_HZ / 1000000);
  localparam int unsigned TSD_DGL_CYC = TSD_DGL_US * (CLK_HZ / 1000000);
  localparam int unsigned SLP_DGL_CYC = SLP_DGL_US * (CLK_HZ / 1000000);
  localparam int unsigned IRQ_PULSE_CYC = IRQ_PULSE_US * (CLK_HZ / 1000000);

  // Millisecond-tick timers
  localparam int unsigned PAUSE_MS     = 1;
  localparam int unsigned REC_SC_MS    = 250;
  localparam int unsigned I2C_IDLE_MS  = 500;
  localparam int unsigned WDOG_S       = 50;
  localparam int unsigned WDOG_MS      = WDOG_S * 1000;
  localparam int unsigned MS_PER_MIN   = 60000;

  // Safety timer range in minutes
  localparam int unsigned SAFETY_MIN_MIN = 180;
  localparam int unsigned SAFETY_MAX_MIN = 720;
  localparam int unsigned PRE_DIV_SHIFT  = 2;

  // Input regulation threshold: 4.2 V at code 0, 100 mV per code
  localparam int unsigned VREG_BASE_MV = 4200;
  localparam int unsigned VREG_STEP_MV = 100;
  localparam logic [2:0]  VREG_RESET   = 3'h3;

  // Counter widths
  localparam int unsigned CNT_W  = 12;
  localparam int unsigned MS_W   = 26;

  // Charge sequencer states, Gray coded along the charge path
  typedef enum logic [2:0] {
    CCSEQ_IDLE  = 3'b000,
    CCSEQ_PRE   = 3'b001,
    CCSEQ_FAST  = 3'b011,
    CCSEQ_DONE  = 3'b010,
    CCSEQ_FAULT = 3'b110
  } ccseq_state_e;

endpackage : ccseq_pkg

/* File: ccseq_dgl_if.sv */
/*
  Interface carrying a comparator into a deglitch filter and its result back.
  Assumes both ends run on the system clock.
*/
`timescale 1ns/100ps
interface ccseq_dgl_if;
  logic raw;
  logic clean;
  modport filt (input raw, output clean);
  modport user (output raw, input clean);
endinterface : ccseq_dgl_if

/* File: ccseq_deglitch.sv */
/*
  Deglitch filter: output follows the synchronised input after it holds steady.
  Assumes the raw input is asynchronous to clk_sys.
*/
`timescale 1ns/100ps
module ccseq_deglitch
  import ccseq_pkg::*;
#(
  parameter int unsigned DGL_CYC = 1
)(
  input  wire logic   clk_sys,
  input  wire logic   rst,
  ccseq_dgl_if.filt   port_dgl
);

  typedef struct packed {
    logic             s1;
    logic             s2;
    logic             out;
    logic [CNT_W-1:0] cnt;
  } ccseq_dgl_s;

  ccseq_dgl_s st_reg;
  ccseq_dgl_s st_next;

  // Count stable cycles of a differing level, then adopt it
  always_comb
  begin
    st_next    = st_reg;
    st_next.s1 = port_dgl.raw;
    st_next.s2 = st_reg.s1;
    if (st_reg.s2 == st_reg.out)
      st_next.cnt = '0;
    else if (st_reg.cnt >= CNT_W'(DGL_CYC - 1))
    begin
      st_next.out = st_reg.s2;
      st_next.cnt = '0;
    end
    else
      st_next.cnt = st_reg.cnt + 1'b1;
  end

  // State register
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign port_dgl.clean = st_reg.out;

  // Output may rise only when the synchronised input was high the cycle before
  dgl_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(st_reg.out) |-> $past(st_reg.s2, 1)) else $error("deglitch rose without input");

endmodule : ccseq_deglitch

/* File: ccseq_top.sv */
/*
  Charge control sequencer: input qualification, charge phases, timers,
  protection deglitch, input regulation loop settings and fault interrupt.
  Assumes comparator inputs are asynchronous and pass synchronisers here;
  host register events arrive as one-cycle pulses from logic on clk_sys.
*/
// Function
// - Charge enabled only with enable pin low and disable bit zero.
// - Valid input with enable pin high keeps charge switch off.
// - Input valid only when lockout, sleep and over-voltage comparators agree.
// - Below low-voltage level use pre-charge current, quarter safety limit.
// - Reaching low-voltage level moves to fast charge with fast current.
// - Terminate at termination current only in fast charge with CV loop.
// - Block termination during input regulation, thermal loop or warm zone.
// - Pause charging about 1 ms on any charge current setting change.
// - Safety timer limit programmable from 180 to 720 minutes.
// - Enabled watchdog expires after 50 s without host activity.
// - Reset interface logic after 500 ms of bus inactivity.
// - Input regulation loop enabled after reset, host may disable it.
// - Input regulation threshold 4.2 V to 4.9 V in 100 mV steps.
// - Output power management loop permanently disabled.
// - Active input regulation loop sets status and suppresses termination.
// - Timer doubling extends safety timer while a loop is active.
// - Supplement mode by rail comparators, over-current protection kept active.
// - No termination while supplement mode is active.
// - Over-voltage fault opens input switch, one 128 us low pulse, flags.
// - Status clears with fault; flag clears on host read after fault.
// - Input removed with battery above lockout switches rail to battery.
// - Over-current deglitched 30 us; 250 ms recovery after short trip.
// - Thermal shutdown deglitched 10 us; sleep exit deglitched 120 us.
// - Watchdog restarts per transaction, off at reset, expiry restores defaults.
// - With doubling, safety timer runs half speed in other loops.
// - Safety expiry disables charge, pulses interrupt, flags until toggle.
`timescale 1ns/100ps
module ccseq_top
  import ccseq_pkg::*;
#(
  parameter int unsigned TICK_CYC = TICK_CYCLES
)(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       charge_en_n,
  input  wire logic       chg_disable,
  input  wire logic       cmp_uvlo_ok,
  input  wire logic       cmp_sleep_ok,
  input  wire logic       cmp_ovp,
  input  wire logic       cmp_lowv_ok,
  input  wire logic       cmp_cv_active,
  input  wire logic       cmp_iterm,
  input  wire logic       cmp_vreg_active,
  input  wire logic       cmp_therm_reg,
  input  wire logic       cmp_temp_warm,
  input  wire logic       cmp_sup_enter,
  input  wire logic       cmp_sup_exit,
  input  wire logic       cmp_bat_uvlo_ok,
  input  wire logic       cmp_bat_ocp,
  input  wire logic       cmp_tsd,
  input  wire logic       host_txn,
  input  wire logic       host_bus_active,
  input  wire logic       host_flag_read,
  input  wire logic       host_iset_wr,
  input  wire logic       host_cfg_wr,
  input  wire logic       wdog_en,
  input  wire logic       timer_doubling,
  input  wire logic [1:0] safety_sel,
  input  wire logic       vreg_loop_dis,
  input  wire logic [2:0] vreg_code,
  output logic            charge_switch_on,
  output logic            use_fast_current,
  output logic            input_switch_on,
  output logic            bat_switch_on,
  output logic            rail_on_battery,
  output logic            supplement_mode,
  output logic            input_voltage_reg_loop,
  output logic [2:0]      input_voltage_reg_code,
  output logic            output_power_mgmt_loop,
  output logic            vreg_loop_stat,
  output logic            input_overvoltage_fault,
  output logic            ovp_flag,
  output logic            safety_flag,
  output logic            charge_done,
  output logic            params_default,
  output logic            i2c_reset,
  output logic            int_n
);

  // Time base counter sized for the tick period, not the short counter width
  localparam int unsigned TICK_W = $clog2(TICK_CYC + 1);

  typedef struct packed {
    logic [1:0]       sync_a;  // Pin synchronisers, stage one
    logic [1:0]       sync_b;
    logic [12:0]      c1;
    logic [12:0]      c2;
    ccseq_state_e     state;
    logic [TICK_W-1:0] tick_cnt;
    logic [MS_W-1:0]  safety_ms;
    logic             half_phase;
    logic [MS_W-1:0]  wdog_ms;
    logic [9:0]       idle_ms;
    logic [7:0]       rec_ms;
    logic [1:0]       pause_ms;
    logic             pausing;
    logic             ovp_prev;
    logic             en_prev;
    logic             valid_prev;
    logic             warm_prev;   // Temperature zone seen last cycle
    logic [CNT_W-1:0] irq_cnt;
    logic             ovp_flag;
    logic             safety_flag;
    logic             sup;
    logic             bat_off;
    logic             vreg_on;
    logic [2:0]       vreg_code;
    logic             params_default;
    logic             i2c_reset;
    logic             chg_sw;
  } ccseq_st_s;

  ccseq_st_s st_reg;
  ccseq_st_s st_next;

  // Deglitched protection comparators
  ccseq_dgl_if dgl_ocp ();
  ccseq_dgl_if dgl_tsd ();
  ccseq_dgl_if dgl_slp ();
  assign dgl_ocp.raw = cmp_bat_ocp;
  assign dgl_tsd.raw = cmp_tsd;
  assign dgl_slp.raw = cmp_sleep_ok;

  ccseq_deglitch #(.DGL_CYC(OCP_DGL_CYC)) u_ocp (.clk_sys(clk_sys), .rst(rst), .port_dgl(dgl_ocp));
  ccseq_deglitch #(.DGL_CYC(TSD_DGL_CYC)) u_tsd (.clk_sys(clk_sys), .rst(rst), .port_dgl(dgl_tsd));
  ccseq_deglitch #(.DGL_CYC(SLP_DGL_CYC)) u_slp (.clk_sys(clk_sys), .rst(rst), .port_dgl(dgl_slp));

  // Safety limit in ms for a select code, 180 to 720 minutes, a quarter of that in pre-charge
  function automatic logic [MS_W-1:0] safety_limit(input logic [1:0] sel, input logic pre);
    logic [MS_W-1:0] mins;
    mins = MS_W'(SAFETY_MIN_MIN) << sel;
    if (mins > MS_W'(SAFETY_MAX_MIN))
      mins = MS_W'(SAFETY_MAX_MIN);
    mins = MS_W'(mins * MS_W'(MS_PER_MIN));
    return pre ? (mins >> PRE_DIV_SHIFT) : mins;
  endfunction : safety_limit

  // Synchronised pin views: second stages only
  logic en_pin_n, uvlo_ok, ovp, lowv_ok, cv_act, iterm, vreg_act, therm, warm;
  logic sup_in, sup_out, bat_uv_ok, input_valid, charge_allow, loop_act, term_ok, tick;
  assign {en_pin_n, uvlo_ok}  = st_reg.sync_b;
  assign {ovp, lowv_ok, cv_act, iterm, vreg_act, therm, warm, sup_in, sup_out, bat_uv_ok}
         = st_reg.c2[9:0];
  assign tick = (st_reg.tick_cnt == TICK_W'(TICK_CYC - 1));

  assign input_valid = uvlo_ok && dgl_slp.clean && !ovp && !dgl_tsd.clean;
  assign charge_allow = !en_pin_n && !chg_disable;
  assign loop_act = (vreg_act && st_reg.vreg_on) || therm;
  assign term_ok = cv_act && iterm && !loop_act && !warm && !st_reg.sup;

  // Next-state logic
  always_comb
  begin
    st_next        = st_reg;
    st_next.sync_a = {charge_en_n, cmp_uvlo_ok};
    st_next.sync_b = st_reg.sync_a;
    st_next.c1     = {3'h0, cmp_ovp, cmp_lowv_ok, cmp_cv_active, cmp_iterm, cmp_vreg_active,
                      cmp_therm_reg, cmp_temp_warm, cmp_sup_enter, cmp_sup_exit, cmp_bat_uvlo_ok};
    st_next.c2     = st_reg.c1;
    st_next.tick_cnt   = tick ? '0 : st_reg.tick_cnt + 1'b1;
    st_next.ovp_prev   = ovp;
    st_next.en_prev    = en_pin_n;
    st_next.valid_prev = input_valid;
    st_next.warm_prev  = warm;
    st_next.params_default = 1'b0;
    st_next.i2c_reset      = 1'b0;
    if (st_reg.irq_cnt != '0)
      st_next.irq_cnt = st_reg.irq_cnt - 1'b1;

    if (host_cfg_wr)
    begin
      st_next.vreg_on   = !vreg_loop_dis;
      st_next.vreg_code = vreg_code;
    end

    if (!wdog_en || host_txn)
      st_next.wdog_ms = '0;
    else if (tick)
    begin
      if (st_reg.wdog_ms >= MS_W'(WDOG_MS - 1))
      begin
        st_next.wdog_ms        = '0;
        st_next.params_default = 1'b1;
        st_next.vreg_on        = 1'b1;
        st_next.vreg_code      = VREG_RESET;
      end
      else
        st_next.wdog_ms = st_reg.wdog_ms + 1'b1;
    end

    if (host_bus_active)
      st_next.idle_ms = '0;
    else if (tick)
    begin
      if (st_reg.idle_ms >= 10'(I2C_IDLE_MS - 1))
      begin
        st_next.idle_ms   = '0;
        st_next.i2c_reset = 1'b1;
      end
      else
        st_next.idle_ms = st_reg.idle_ms + 1'b1;
    end

    if (sup_in)
      st_next.sup = 1'b1;
    else if (sup_out)
      st_next.sup = 1'b0;

    if (dgl_ocp.clean && !st_reg.bat_off)
    begin
      st_next.bat_off = 1'b1;
      st_next.rec_ms  = '0;
    end
    else if (st_reg.bat_off && tick)
    begin
      if (st_reg.rec_ms >= 8'(REC_SC_MS - 1))
        st_next.bat_off = 1'b0;
      else
        st_next.rec_ms = st_reg.rec_ms + 1'b1;
    end

    // over-voltage onset pulses interrupt; flag set wins over read
    if (ovp && !st_reg.ovp_prev)
    begin
      st_next.ovp_flag = 1'b1;
      st_next.irq_cnt  = CNT_W'(IRQ_PULSE_CYC);
    end
    else if (host_flag_read && !ovp)
      st_next.ovp_flag = 1'b0;

    if (st_reg.pausing && tick)
    begin
      if (st_reg.pause_ms >= 2'(PAUSE_MS))
        st_next.pausing = 1'b0;
      else
        st_next.pause_ms = st_reg.pause_ms + 1'b1;
    end

    // Charge phase sequencer
    unique case (st_reg.state)
      CCSEQ_IDLE:
      begin
        st_next.safety_ms = '0;
        if (input_valid && charge_allow)
        begin
          st_next.state = lowv_ok ? CCSEQ_FAST : CCSEQ_PRE;
        end
      end
      CCSEQ_PRE, CCSEQ_FAST:
      begin
        // half speed with timer doubling while a loop or the warm zone is active
        if (tick)
        begin
          st_next.half_phase = !st_reg.half_phase;
          if (!(timer_doubling && (loop_act || warm)) || st_reg.half_phase)
            st_next.safety_ms = st_reg.safety_ms + 1'b1;
        end
        if (!input_valid || !charge_allow)
          st_next.state = CCSEQ_IDLE;
        else if (st_reg.safety_ms >= safety_limit(safety_sel, st_reg.state == CCSEQ_PRE))
        begin
          st_next.state       = CCSEQ_FAULT;
          st_next.safety_flag = 1'b1;
          st_next.irq_cnt     = CNT_W'(IRQ_PULSE_CYC);
        end
        else if (st_reg.state == CCSEQ_PRE && lowv_ok)
          st_next.state = CCSEQ_FAST;
        else if (st_reg.state == CCSEQ_FAST && term_ok && !st_reg.pausing)
          st_next.state = CCSEQ_DONE;
      end
      CCSEQ_DONE:
        if (!input_valid || !charge_allow)
          st_next.state = CCSEQ_IDLE;
      CCSEQ_FAULT:
        // cleared only by pin or input toggle
        if (en_pin_n != st_reg.en_prev || (input_valid && !st_reg.valid_prev))
        begin
          st_next.state       = CCSEQ_IDLE;
          st_next.safety_flag = 1'b0;
        end
      default:
        st_next.state = CCSEQ_IDLE;
    endcase

    // any current setting change starts a pause
    if (host_iset_wr || (st_reg.state == CCSEQ_PRE && st_next.state == CCSEQ_FAST)
        || (warm != st_reg.warm_prev))
    begin
      st_next.pausing  = 1'b1;
      st_next.pause_ms = '0;
    end
    // charge switch only in active phases outside pause
    st_next.chg_sw = (st_next.state == CCSEQ_PRE || st_next.state == CCSEQ_FAST)
                     && !st_next.pausing && input_valid && charge_allow;
  end

  // State register
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      st_reg           <= '0;
      st_reg.vreg_on   <= 1'b1;
      st_reg.vreg_code <= VREG_RESET;
    end
    else
      st_reg <= st_next;
  end

  // Registered outputs
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      charge_switch_on        <= 1'b0;
      use_fast_current        <= 1'b0;
      input_switch_on         <= 1'b0;
      bat_switch_on           <= 1'b1;
      rail_on_battery         <= 1'b0;
      supplement_mode         <= 1'b0;
      input_voltage_reg_loop  <= 1'b1;
      input_voltage_reg_code  <= VREG_RESET;
      output_power_mgmt_loop  <= 1'b0;
      vreg_loop_stat          <= 1'b0;
      input_overvoltage_fault <= 1'b0;
      ovp_flag                <= 1'b0;
      safety_flag             <= 1'b0;
      charge_done             <= 1'b0;
      params_default          <= 1'b0;
      i2c_reset               <= 1'b0;
      int_n                   <= 1'b1;
    end
    else
    begin
      charge_switch_on        <= st_reg.chg_sw;
      use_fast_current        <= st_reg.state == CCSEQ_FAST;
      input_switch_on         <= input_valid;
      bat_switch_on           <= !st_reg.bat_off;
      // rail to battery on input loss
      rail_on_battery         <= !input_valid && bat_uv_ok;
      supplement_mode         <= st_reg.sup;
      input_voltage_reg_loop  <= st_reg.vreg_on;
      input_voltage_reg_code  <= st_reg.vreg_code;
      output_power_mgmt_loop  <= 1'b0;
      vreg_loop_stat          <= vreg_act && st_reg.vreg_on;
      input_overvoltage_fault <= ovp;
      ovp_flag                <= st_reg.ovp_flag;
      safety_flag             <= st_reg.safety_flag;
      charge_done             <= st_reg.state == CCSEQ_DONE;
      params_default          <= st_reg.params_default;
      i2c_reset               <= st_reg.i2c_reset;
      int_n                   <= st_reg.irq_cnt == '0;
    end
  end

  chg_enable_a: assert property (@(posedge clk_sys) disable iff (rst)
    st_reg.chg_sw |-> !$past(en_pin_n) && !$past(chg_disable))
    else $error("charging while disabled");
  pin_off_a: assert property (@(posedge clk_sys) disable iff (rst)
    (en_pin_n && input_valid) |=> !st_reg.chg_sw) else $error("switch on with pin high");
  sequence ovp_onset_s;
    ovp && !st_reg.ovp_prev;
  endsequence
  ovp_pulse_a: assert property (@(posedge clk_sys) disable iff (rst)
    ovp_onset_s |=> (st_reg.irq_cnt != '0)[*8] ##0 st_reg.ovp_flag) else $error("ovp pulse short");
  ovp_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    (st_reg.ovp_flag && ovp) |=> st_reg.ovp_flag) else $error("ovp flag lost during fault");
  opm_off_a: assert property (@(posedge clk_sys) disable iff (rst)
    !output_power_mgmt_loop) else $error("output loop enabled");
  term_cv_a: assert property (@(posedge clk_sys) disable iff (rst)
    (st_reg.state == CCSEQ_FAST && st_next.state == CCSEQ_DONE) |-> cv_act) else $error("term no cv");
  term_sup_a: assert property (@(posedge clk_sys) disable iff (rst)
    st_reg.sup |=> !(st_reg.state == CCSEQ_DONE && $past(st_reg.state) == CCSEQ_FAST))
    else $error("term in supplement");
  fault_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    (st_reg.state == CCSEQ_FAULT && $stable(en_pin_n) && !(input_valid && !st_reg.valid_prev))
    |=> st_reg.state == CCSEQ_FAULT) else $error("safety fault left early");

endmodule : ccseq_top

/* File: ccseq_host_model.sv */
/*
  Behavioural host that raises register event pulses on the sequencer.
  Assumes it shares clk_sys and changes its outputs just after an edge.
*/
`timescale 1ns/100ps
module ccseq_host_model
  import ccseq_pkg::*;
(
  input  wire logic clk_sys,
  output logic       host_txn,
  output logic       host_flag_read,
  output logic       host_cfg_wr,
  output logic       host_iset_wr,
  output logic       vreg_loop_dis,
  output logic [2:0] vreg_code
);
  // Quiet bus at start, loop left enabled
  initial
  begin
    host_txn = 1'b0;
    host_flag_read = 1'b0;
    host_cfg_wr = 1'b0;
    host_iset_wr = 1'b0;
    vreg_loop_dis = 1'b0;
    vreg_code = 3'h3;
  end

  task automatic cfg_write(input logic dis, input logic [2:0] code);
    @(posedge clk_sys);
    #1;
    vreg_loop_dis = dis;
    vreg_code = code;
    host_cfg_wr = 1'b1;
    host_txn = 1'b1;
    @(posedge clk_sys);
    #1;
    host_cfg_wr = 1'b0;
    host_txn = 1'b0;
  endtask : cfg_write

  // host write of the charge current
  task automatic iset_write();
    @(posedge clk_sys);
    #1;
    host_iset_wr = 1'b1;
    host_txn = 1'b1;
    @(posedge clk_sys);
    #1;
    host_iset_wr = 1'b0;
    host_txn = 1'b0;
  endtask : iset_write

  // One-cycle read of the flag register
  task automatic flag_read();
    @(posedge clk_sys);
    #1;
    host_flag_read = 1'b1;
    @(posedge clk_sys);
    #1;
    host_flag_read = 1'b0;
  endtask : flag_read
endmodule : ccseq_host_model

/* File: ccseq_top_tb.sv */
/*
  Self-checking bench for the charge sequencer top.
  Assumes a shortened time base of 20 cycles per tick.
*/
`timescale 1ns/100ps
module ccseq_top_tb
  import ccseq_pkg::*;
;
  logic clk_sys, rst, charge_en_n, chg_disable, cmp_uvlo_ok, cmp_sleep_ok, cmp_ovp;
  logic cmp_lowv_ok, cmp_cv_active, cmp_iterm, cmp_vreg_active, cmp_therm_reg, cmp_temp_warm;
  logic cmp_sup_enter, cmp_sup_exit, cmp_bat_uvlo_ok, cmp_bat_ocp, cmp_tsd, host_bus_active;
  logic wdog_en, timer_doubling, host_txn, host_flag_read, host_iset_wr, host_cfg_wr;
  logic vreg_loop_dis, charge_switch_on, use_fast_current, input_switch_on, bat_switch_on;
  logic rail_on_battery, supplement_mode, input_voltage_reg_loop, output_power_mgmt_loop;
  logic vreg_loop_stat, input_overvoltage_fault, ovp_flag, safety_flag, charge_done, int_n;
  logic i2c_reset;
  logic [1:0] safety_sel;
  logic [2:0] vreg_code, input_voltage_reg_code;
  int bad_count, tests_run, n;

  // Device under test with a short tick
  ccseq_top #(.TICK_CYC(20)) dut (.clk_sys, .rst, .charge_en_n, .chg_disable, .cmp_uvlo_ok,
    .cmp_sleep_ok, .cmp_ovp, .cmp_lowv_ok, .cmp_cv_active, .cmp_iterm, .cmp_vreg_active,
    .cmp_therm_reg, .cmp_temp_warm, .cmp_sup_enter, .cmp_sup_exit, .cmp_bat_uvlo_ok,
    .cmp_bat_ocp, .cmp_tsd, .host_txn, .host_bus_active, .host_flag_read, .host_iset_wr,
    .host_cfg_wr, .wdog_en, .timer_doubling, .safety_sel, .vreg_loop_dis, .vreg_code,
    .charge_switch_on, .use_fast_current, .input_switch_on, .bat_switch_on, .rail_on_battery,
    .supplement_mode, .input_voltage_reg_loop, .input_voltage_reg_code,
    .output_power_mgmt_loop, .vreg_loop_stat, .input_overvoltage_fault, .ovp_flag,
    .safety_flag, .charge_done, .params_default(), .i2c_reset, .int_n);

  // Host side partner
  ccseq_host_model host (.clk_sys, .host_txn, .host_flag_read, .host_cfg_wr, .host_iset_wr,
    .vreg_loop_dis, .vreg_code);

  // 20 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic step(input int c);
    repeat (c) @(posedge clk_sys);
    #1;
  endtask : step

  task automatic chk(input string nm, input logic [2:0] exp, input logic [2:0] got);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run

  task automatic t_enable();
    for (int i = 0; i < 4; i++)
    begin
      charge_en_n = i[1];
      chg_disable = i[0];
      step(80);
      chk("charge_switch_on", {2'h0, i == 0}, {2'h0, charge_switch_on});
    end
    charge_en_n = 1'b0;
    chg_disable = 1'b0;
    step(80);
    chk("use_fast_current", 3'h0, {2'h0, use_fast_current});
  endtask : t_enable

  task automatic t_fast();
    cmp_lowv_ok = 1'b1;
    step(12);
    chk("pause", 3'h0, {2'h0, charge_switch_on});
    step(80);
    chk("fast", 3'h3, {1'b0, use_fast_current, charge_switch_on});
    host.iset_write();
    step(2);
    chk("iset_pause", 3'h0, {2'h0, charge_switch_on});
    step(80);
    cmp_temp_warm = 1'b1;
    step(6);
    chk("warm_pause", 3'h0, {2'h0, charge_switch_on});
    cmp_temp_warm = 1'b0;
    step(80);
    chk("resumed", 3'h1, {2'h0, charge_switch_on});
  endtask : t_fast

  task automatic t_term();
    cmp_iterm = 1'b1;
    step(10);
    chk("done_no_cv", 3'h0, {2'h0, charge_done});
    cmp_cv_active = 1'b1;
    cmp_vreg_active = 1'b1;
    step(10);
    chk("vreg_block", 3'h1, {1'b0, charge_done, vreg_loop_stat});
    cmp_sup_enter = 1'b1;
    step(10);
    cmp_vreg_active = 1'b0;
    step(10);
    chk("sup_block", 3'h1, {1'b0, charge_done, supplement_mode});
    cmp_sup_enter = 1'b0;
    cmp_sup_exit = 1'b1;
    step(10);
    cmp_sup_exit = 1'b0;
    step(10);
    chk("done", 3'h2, {1'b0, charge_done, supplement_mode});
  endtask : t_term

  task automatic t_ovp();
    cmp_ovp = 1'b1;
    for (n = 0; n < 20 && int_n !== 1'b0; n++)
      step(1);
    for (n = 0; n < 3000 && int_n === 1'b0; n++)
      step(1);
    chk("int_width", 3'h0, (n == IRQ_PULSE_CYC) ? 3'h0 : 3'h7);
    chk("ovp_set", 3'h3, {input_switch_on, input_overvoltage_fault, ovp_flag});
    chk("rail_bat", 3'h1, {2'h0, rail_on_battery});
    cmp_ovp = 1'b0;
    step(10);
    chk("ovp_gone", 3'h5, {input_switch_on, input_overvoltage_fault, ovp_flag});
    chk("rail_in", 3'h0, {2'h0, rail_on_battery});
    host.flag_read();
    step(2);
    chk("flag_read", 3'h0, {2'h0, ovp_flag});
  endtask : t_ovp

  task automatic t_cfg();
    host.cfg_write(1'b1, 3'h7);
    step(4);
    chk("vreg_code", 3'h7, input_voltage_reg_code);
    chk("vreg_off", 3'h0, {1'b0, input_voltage_reg_loop, output_power_mgmt_loop});
  endtask : t_cfg

  // Over-current deglitch, trip and recovery
  task automatic t_ocp();
    cmp_bat_ocp = 1'b1;
    step(590);
    chk("ocp_dgl", 3'h1, {2'h0, bat_switch_on});
    step(30);
    cmp_bat_ocp = 1'b0;
    chk("ocp_trip", 3'h0, {2'h0, bat_switch_on});
    step(4900);
    chk("ocp_rec_wait", 3'h0, {2'h0, bat_switch_on});
    step(100);
    chk("ocp_rec", 3'h1, {2'h0, bat_switch_on});
  endtask : t_ocp

  // Bus inactivity resets the interface after 500 ticks
  task automatic t_idle();
    host_bus_active = 1'b0;
    for (n = 0; n < 10100 && i2c_reset !== 1'b1; n++)
      step(1);
    host_bus_active = 1'b1;
    chk("idle_time", 3'h1, {2'h0, n > 9980 && n < 10010});
    step(1);
    chk("idle_pulse", 3'h0, {2'h0, i2c_reset});
  endtask : t_idle

  // Watchdog for a hung run, about twice the expected run length
  initial
  begin
    #2000000;
    bad_count++;
    complete_run();
  end

  // Main sequence
  initial
  begin
    {cmp_ovp, cmp_lowv_ok, cmp_cv_active, cmp_iterm, cmp_vreg_active, cmp_therm_reg} = '0;
    {cmp_temp_warm, cmp_sup_enter, cmp_sup_exit, cmp_bat_ocp, cmp_tsd, wdog_en} = '0;
    {cmp_uvlo_ok, cmp_sleep_ok, cmp_bat_uvlo_ok, host_bus_active, charge_en_n} = '1;
    {chg_disable, timer_doubling, safety_sel} = '0;
    bad_count = 0;
    tests_run = 0;
    rst = 1'b1;
    step(2);
    rst = 1'b0;
    step(1);
    chk("reset_a", 3'h7, {bat_switch_on, input_voltage_reg_loop, int_n});
    chk("reset_code", 3'h3, input_voltage_reg_code);
    chk("reset_opm", 3'h0, {1'b0, output_power_mgmt_loop, charge_switch_on});
    step(SLP_DGL_CYC - 10);
    chk("slp_dgl_early", 3'h0, {2'h0, input_switch_on});
    step(20);
    chk("slp_dgl_done", 3'h1, {2'h0, input_switch_on});
    t_enable();
    t_fast();
    t_term();
    t_ovp();
    t_cfg();
    t_ocp();
    t_idle();
    complete_run();
  end
endmodule : ccseq_top_tb
